// file: hgd_core.sv
// High-band gain decode, pulse limiting and subframe energy smoothing
// Assumes the external synthesis filter accepts limited excitation and returns its output
`timescale 1ns/1ns
module hgd_core (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_frame_valid,
    input wire hgd_pkg::hgd_frame_t i_frame,
    output logic o_frame_ready,
    output logic o_gain_valid,
    output logic [15:0] o_gain_lin,
    output logic signed [15:0] o_gain_db,
    input wire hgd_pkg::hgd_sample_t i_exc,
    output hgd_pkg::hgd_sample_t o_exc,
    input wire hgd_pkg::hgd_sample_t i_syn,
    output logic o_syn_ready,
    output hgd_pkg::hgd_sample_t o_syn
);
    typedef struct packed {
        hgd_pkg::hgd_state_t st;
        hgd_pkg::hgd_frame_t fr;
        logic [4:0] nb;
        logic [4:0] sf;
        logic signed [15:0] mem;
        logic signed [15:0] old_match;
        logic [63:0] g1;
        logic [39:0] env;
        logic [39:0] thres;
        logic [39:0] energy;
        logic [5:0] cnt;
        logic [1023:0] buf_s;
        logic [15:0] scale;
        logic [15:0] root;
        logic [4:0] rbit;
        logic gv;
        logic [15:0] glin;
        logic signed [15:0] gdb;
        hgd_pkg::hgd_sample_t exc;
        hgd_pkg::hgd_sample_t syn;
    } hgd_core_t;
    hgd_core_t r_ff;
    hgd_core_t nxt_r;
    logic signed [15:0] cb_mem [0:511];
    // Codebook contents, dB in Q8.8; loaded as a constant table
    initial
    begin
        for (int k = 0; k < 512; k++)
        begin
            cb_mem[k] = 16'(signed'((k % 13) * 64 - 384));
        end
    end
    function automatic logic [15:0] db_to_lin(input logic signed [15:0] db);
        logic signed [31:0] l2;
        logic [4:0] ip;
        logic [15:0] fr;
        logic [31:0] m;
        begin
            // 10^(x/20) = 2^(x*0.16610), 0.16610 = 10885/65536
            l2 = (32'(db) * 32'sd10885) >>> 16;
            ip = 5'(l2 >>> 8);
            fr = 16'h1000 + 16'(((l2 & 32'sd255) * 32'sd2839) >>> 8);
            m = 32'(fr);
            if (l2 >= 32'sd1024)
                db_to_lin = 16'hFFFF;
            else if (l2 < -32'sd3072)
                db_to_lin = 16'h0000;
            else if (l2 >= 0)
                db_to_lin = 16'(m << ip);
            else
                db_to_lin = 16'(m >> (5'h00 - ip));
        end
    endfunction : db_to_lin
    function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
        begin
            if (v > 40'sd32767)
                sat16 = 16'sh7FFF;
            else if (v < -40'sd32768)
                sat16 = 16'sh8000;
            else
                sat16 = 16'(v);
        end
    endfunction : sat16
    logic signed [15:0] ga [0:3];
    logic signed [15:0] gsum;
    logic signed [31:0] w1;
    logic signed [15:0] est;
    logic signed [15:0] c1;
    logic signed [15:0] c2;
    logic [2:0] i2;
    logic signed [16:0] mag;
    logic [39:0] lim;
    logic [39:0] delta;
    logic signed [39:0] envn;
    logic [39:0] trial;
    logic [79:0] tsq;
    logic [79:0] q;
    logic signed [31:0] prod;
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.gv = 1'b0;
        nxt_r.exc.valid = 1'b0;
        nxt_r.syn.valid = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            ga[k] = 16'sh0000;
        end
        gsum = 16'sh0000;
        w1 = 32'sd0;
        est = 16'sh0000;
        c1 = 16'sh0000;
        c2 = 16'sh0000;
        i2 = 3'h0;
        mag = 17'sd0;
        lim = 40'h0;
        delta = 40'h0;
        envn = 40'sd0;
        trial = 40'h0;
        tsq = 80'h0;
        q = 80'h0;
        prod = 32'sd0;
        unique case (r_ff.st)
            hgd_pkg::HGD_IDLE:
            begin
                if (i_frame_valid)
                begin
                    nxt_r.fr = i_frame;
                    nxt_r.sf = 5'h00;
                    unique case (i_frame.size)
                        hgd_pkg::HGD_SHORT: nxt_r.nb = hgd_pkg::SF_SHORT;
                        hgd_pkg::HGD_MEDIUM: nxt_r.nb = hgd_pkg::SF_MEDIUM;
                        default: nxt_r.nb = hgd_pkg::SF_LONG;
                    endcase
                    if (i_frame.loss[0])
                    begin
                        w1 = 32'(r_ff.mem + hgd_pkg::DB_20) * 32'(signed'({1'b0, hgd_pkg::ALPHA_Q15}));
                        nxt_r.mem = 16'(w1 >>> 15) - hgd_pkg::DB_20;
                        for (int k = 0; k < 4; k++)
                        begin
                            ga[k] = nxt_r.mem + hgd_pkg::GAIN_MEAN;
                        end
                    end
                    else
                    begin
                        for (int k = 0; k < 4; k++)
                        begin
                            ga[k] = cb_mem[{i_frame.idx1, 2'(k)}] + hgd_pkg::GAIN_MEAN;
                        end
                        w1 = 32'(ga[0]) + 32'(ga[1]) + 32'(ga[2]) + 32'(ga[3]);
                        gsum = 16'(w1 >>> 2);
                        nxt_r.mem = gsum - hgd_pkg::GAIN_MEAN;
                    end
                    nxt_r.g1 = {ga[3], ga[2], ga[1], ga[0]};
                    nxt_r.st = hgd_pkg::HGD_GAIN;
                end
            end
            hgd_pkg::HGD_GAIN:
            begin
                // Interpolation weight sf/nb, nb a power of two
                w1 = 32'(r_ff.fr.g_match) * 32'(r_ff.sf)
                    + 32'(r_ff.old_match) * 32'(r_ff.nb - r_ff.sf);
                unique case (r_ff.fr.size)
                    hgd_pkg::HGD_SHORT: est = 16'(w1 >>> 2);
                    hgd_pkg::HGD_MEDIUM: est = 16'(w1 >>> 3);
                    default: est = 16'(w1 >>> 4);
                endcase
                unique case (r_ff.fr.size)
                    hgd_pkg::HGD_SHORT: c1 = 16'(r_ff.g1 >> {r_ff.sf[1:0], 4'h0});
                    hgd_pkg::HGD_MEDIUM: c1 = 16'(r_ff.g1 >> {r_ff.sf[2:1], 4'h0});
                    default: c1 = 16'(r_ff.g1 >> {r_ff.sf[3:2], 4'h0});
                endcase
                i2 = 3'(r_ff.fr.idx2 >> (6'h03 * 6'(r_ff.sf)));
                if (r_ff.fr.size == hgd_pkg::HGD_SHORT)
                    c2 = 16'sh0000;
                else if (r_ff.fr.loss[0])
                    c2 = 16'sh0000;
                else if (r_ff.fr.size == hgd_pkg::HGD_MEDIUM)
                    c2 = 16'(hgd_pkg::DB_3 * 16'(i2[1:0])) - hgd_pkg::DB_4P5;
                else
                    c2 = 16'(hgd_pkg::DB_3 * 16'(i2)) - hgd_pkg::DB_10P5;
                nxt_r.gdb = est + c1 + c2;
                nxt_r.glin = db_to_lin(nxt_r.gdb);
                nxt_r.gv = 1'b1;
                nxt_r.cnt = 6'h00;
                nxt_r.energy = hgd_pkg::EN_FLOOR;
                nxt_r.st = hgd_pkg::HGD_EXC;
            end
            hgd_pkg::HGD_EXC:
            begin
                // Excitation limited and synthesis output gathered in the same cycle
                if (i_exc.valid)
                begin
                    mag = i_exc.data[15] ? -17'(i_exc.data) : 17'(i_exc.data);
                    // Envelope follows sample magnitude and is updated before the pulse test
                    envn = 40'((64'(mag) * 64'(hgd_pkg::ENV_NUM_Q15))
                        + ((64'(r_ff.env) * 64'(hgd_pkg::ENV_POLE_Q15)) >> 15));
                    lim = 40'(envn) << 1;
                    delta = (40'(mag) << 15) > lim ? (40'(mag) << 15) - lim : 40'h0;
                    nxt_r.env = 40'(envn) + (delta >> 1);
                    nxt_r.exc.valid = 1'b1;
                    nxt_r.exc.data = i_exc.data[15] ? 16'(i_exc.data + 16'(delta >> 15))
                        : 16'(i_exc.data - 16'(delta >> 15));
                end
                if (i_syn.valid)
                begin
                    nxt_r.buf_s[r_ff.cnt * 16 +: 16] = i_syn.data;
                    nxt_r.energy = r_ff.energy
                        + 40'(unsigned'(32'(i_syn.data) * 32'(i_syn.data)));
                    nxt_r.cnt = r_ff.cnt + 6'h01;
                    if (r_ff.cnt == 6'(hgd_pkg::SF_LEN - 1))
                        nxt_r.st = hgd_pkg::HGD_ACC;
                end
            end
            hgd_pkg::HGD_ACC:
            begin
                if (r_ff.thres == hgd_pkg::THRES_RST)
                    nxt_r.thres = r_ff.energy;
                else if (r_ff.energy < r_ff.thres)
                begin
                    trial = 40'((80'(r_ff.energy) * 80'(hgd_pkg::SQRT2_Q12)) >> 12);
                    nxt_r.thres = trial < r_ff.thres ? trial : r_ff.thres;
                end
                else
                begin
                    trial = 40'((80'(r_ff.energy) * 80'(hgd_pkg::INV_SQRT2_Q15)) >> 15);
                    nxt_r.thres = trial > r_ff.thres ? trial : r_ff.thres;
                end
                nxt_r.root = 16'h0000;
                nxt_r.rbit = 5'h0F;
                nxt_r.st = hgd_pkg::HGD_ROOT;
            end
            hgd_pkg::HGD_ROOT:
            begin
                // Bitwise square root of thres/energy in Q4.12
                trial = 40'(r_ff.root | (16'h0001 << r_ff.rbit));
                tsq = 80'(trial) * 80'(trial) * 80'(r_ff.energy);
                q = 80'(r_ff.thres) << 24;
                if (tsq <= q)
                    nxt_r.root = 16'(trial);
                nxt_r.rbit = r_ff.rbit - 5'h01;
                if (r_ff.rbit == 5'h00)
                begin
                    nxt_r.cnt = 6'h00;
                    nxt_r.st = hgd_pkg::HGD_OUT;
                end
            end
            hgd_pkg::HGD_OUT:
            begin
                prod = 32'(signed'(r_ff.buf_s[r_ff.cnt * 16 +: 16]))
                    * 32'(signed'({1'b0, r_ff.root}));
                nxt_r.syn.valid = 1'b1;
                nxt_r.syn.data = sat16(40'(prod >>> hgd_pkg::LIN_FRAC));
                nxt_r.cnt = r_ff.cnt + 6'h01;
                if (r_ff.cnt == 6'(hgd_pkg::SF_LEN - 1))
                begin
                    nxt_r.sf = r_ff.sf + 5'h01;
                    if (r_ff.sf + 5'h01 == r_ff.nb)
                    begin
                        nxt_r.old_match = r_ff.fr.g_match;
                        nxt_r.st = hgd_pkg::HGD_IDLE;
                    end
                    else
                        nxt_r.st = hgd_pkg::HGD_GAIN;
                end
            end
            default:
                nxt_r.st = hgd_pkg::HGD_IDLE;
        endcase
    end
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            r_ff <= '0;
            r_ff.mem <= hgd_pkg::PRED_MEM_RST;
            r_ff.env <= 40'h0;
            r_ff.thres <= hgd_pkg::THRES_RST;
        end
        else
            r_ff <= nxt_r;
    end
    assign o_frame_ready = (r_ff.st == hgd_pkg::HGD_IDLE);
    assign o_syn_ready = (r_ff.st == hgd_pkg::HGD_EXC);
    assign o_gain_valid = r_ff.gv;
    assign o_gain_lin = r_ff.glin;
    assign o_gain_db = r_ff.gdb;
    assign o_exc = r_ff.exc;
    assign o_syn = r_ff.syn;
endmodule : hgd_core

// file: hgd_pkg.sv
// Constants, types and fixed-point formats for the high-band gain decode and smoothing block
// Assumes a single 25 MHz clock domain; all values in signed or unsigned fixed point as listed below
package hgd_pkg;
    // dB values: signed Q8.8 in 16 bits
    localparam int DB_W = 16;
    localparam int DB_FRAC = 8;
    // Samples: signed Q1.15 in 16 bits
    localparam int SMP_W = 16;
    // Linear gain and scale: unsigned Q4.12
    localparam int LIN_W = 16;
    localparam int LIN_FRAC = 12;
    // Energy: unsigned Q10.30 word, 40 bits
    localparam int EN_W = 40;
    localparam int SF_LEN = 64;
    localparam logic [4:0] SF_SHORT = 5'h04;
    localparam logic [4:0] SF_MEDIUM = 5'h08;
    localparam logic [4:0] SF_LONG = 5'h10;
    localparam logic signed [15:0] DB_MINUS20 = 16'shEC00;
    localparam logic signed [15:0] DB_20 = 16'sh1400;
    localparam logic signed [15:0] DB_3 = 16'sh0300;
    localparam logic signed [15:0] DB_4P5 = 16'sh0480;
    localparam logic signed [15:0] DB_10P5 = 16'sh0A80;
    localparam logic [15:0] ALPHA_Q15 = 16'h7333;
    localparam logic [15:0] ENV_NUM_Q15 = 16'h028F;
    localparam logic [15:0] ENV_POLE_Q15 = 16'h7D71;
    localparam logic [39:0] EN_FLOOR = 40'h000001A36E;
    localparam logic [15:0] SQRT2_Q12 = 16'h16A0;
    localparam logic [15:0] INV_SQRT2_Q15 = 16'h5A82;
    localparam logic signed [15:0] PRED_MEM_RST = 16'sh0000;
    localparam logic [39:0] THRES_RST = 40'h0000000000;
    localparam logic signed [15:0] GAIN_MEAN = 16'shF800;
    typedef enum logic [1:0] {
        HGD_SHORT = 2'h0,
        HGD_MEDIUM = 2'h1,
        HGD_LONG = 2'h2
    } hgd_size_t;
    typedef enum logic [2:0] {
        HGD_IDLE = 3'h0,
        HGD_GAIN = 3'h1,
        HGD_EXC = 3'h2,
        HGD_ACC = 3'h3,
        HGD_ROOT = 3'h4,
        HGD_OUT = 3'h5
    } hgd_state_t;
    typedef struct packed {
        hgd_size_t size;
        logic [3:0] loss;
        logic [6:0] idx1;
        logic [47:0] idx2;
        logic signed [15:0] g_match;
    } hgd_frame_t;
    typedef struct packed {
        logic valid;
        logic signed [15:0] data;
    } hgd_sample_t;
endpackage : hgd_pkg

// file: hgd_core_properties.sv
// Port-level assertions for hgd_core
// Assumes one clock domain with asynchronous active-low reset
`timescale 1ns/1ns
module hgd_core_properties (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_frame_valid,
    input wire hgd_pkg::hgd_frame_t i_frame,
    input wire logic o_frame_ready,
    input wire logic o_gain_valid,
    input wire logic [15:0] o_gain_lin,
    input wire logic signed [15:0] o_gain_db,
    input wire hgd_pkg::hgd_sample_t i_exc,
    input wire hgd_pkg::hgd_sample_t o_exc,
    input wire hgd_pkg::hgd_sample_t i_syn,
    input wire logic o_syn_ready,
    input wire hgd_pkg::hgd_sample_t o_syn
);
    default clocking dcb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    logic [6:0] run_ff;
    logic [5:0] acc_ff;
    logic [4:0] gcnt_ff;
    logic [4:0] nb_ff;
    wire logic take = i_frame_valid && o_frame_ready;
    wire logic syn_in = i_syn.valid && o_syn_ready;
    function automatic logic [15:0] mag(input logic [15:0] v);
        return v[15] ? 16'(-v) : v;
    endfunction : mag
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            run_ff <= 7'h00;
            acc_ff <= 6'h00;
            gcnt_ff <= 5'h00;
            nb_ff <= 5'h00;
        end
        else
        begin
            run_ff <= o_syn.valid ? run_ff + 7'h01 : 7'h00;
            acc_ff <= acc_ff + 6'(syn_in);
            gcnt_ff <= take ? 5'h00 : gcnt_ff + 5'(o_gain_valid);
            if (take)
                nb_ff <= (i_frame.size == hgd_pkg::HGD_SHORT) ? hgd_pkg::SF_SHORT :
                    (i_frame.size == hgd_pkg::HGD_MEDIUM) ? hgd_pkg::SF_MEDIUM : hgd_pkg::SF_LONG;
        end
    end
    frame_answer_a: assert property (take |-> ##[2:3] o_gain_valid)
        else $error("no gain pulse after frame");
    frame_busy_a: assert property (take |=> !o_frame_ready)
        else $error("ready stayed high after frame");
    frame_count_a: assert property ($rose(o_frame_ready) |-> gcnt_ff == nb_ff)
        else $error("wrong subframe count");
    gain_pulse_a: assert property (o_gain_valid |=> !o_gain_valid)
        else $error("gain pulse too long");
    exc_latency_a: assert property (i_exc.valid && o_syn_ready |=> o_exc.valid)
        else $error("excitation not answered");
    exc_sign_a: assert property (o_exc.valid && o_exc.data != 16'h0000 |->
        o_exc.data[15] == $past(i_exc.data[15])) else $error("excitation sign lost");
    exc_bound_a: assert property (o_exc.valid |->
        mag(o_exc.data) <= mag($past(i_exc.data))) else $error("excitation grew");
    burst_len_a: assert property ($fell(o_syn.valid) |-> run_ff == 7'h40)
        else $error("output burst not 64");
    burst_start_a: assert property (syn_in && acc_ff == 6'h3F |-> ##[18:20]
        $rose(o_syn.valid)) else $error("output burst late");
    ready_split_a: assert property (!(o_frame_ready && o_syn_ready))
        else $error("both readies high");
    cover property (take && i_frame.size == hgd_pkg::HGD_LONG);
    cover property ($fell(o_syn.valid));
    cover property (o_exc.valid && o_exc.data != $past(i_exc.data));
endmodule : hgd_core_properties

bind hgd_core hgd_core_properties hgd_core_properties_inst (
    .i_clock, .i_rstn, .i_frame_valid, .i_frame, .o_frame_ready, .o_gain_valid,
    .o_gain_lin, .o_gain_db, .i_exc, .o_exc, .i_syn, .o_syn_ready, .o_syn
);

// file: hgd_partner.sv
// Far-side model streaming excitation and synthesis-filter samples
// Assumes a sample is taken at each edge with valid and ready high
`timescale 1ns/1ns
module hgd_partner (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_slow,
    input wire logic [63:0] i_amps,
    input wire logic i_ready,
    output hgd_pkg::hgd_sample_t o_exc,
    output hgd_pkg::hgd_sample_t o_syn
);
    logic [7:0] cnt_ff;
    logic tick_ff;
    logic [15:0] amp;
    logic [15:0] ex;
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt_ff <= 8'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= ~tick_ff;
            if (o_syn.valid && i_ready)
                cnt_ff <= cnt_ff + 8'h01;
        end
    end
    // Subframe level picked per 64 taken samples; invalid cycles show inverted data
    always_comb
    begin
        amp = i_amps[{cnt_ff[7:6], 4'h0} +: 16];
        ex = cnt_ff[0] ? 16'hC000 : 16'h4000;
        o_syn.valid = !i_slow || tick_ff;
        o_syn.data = o_syn.valid ? amp : ~amp;
        o_exc.valid = o_syn.valid;
        o_exc.data = o_syn.valid ? ex : ~ex;
    end
endmodule : hgd_partner

// file: tb_hgd_core.sv
// Self-checking bench for hgd_core with the streaming far-side model
// Assumes hgd_pkg, hgd_core, hgd_partner and the bound checker compiled first
`timescale 1ns/1ns
module tb_hgd_core;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_frame_valid = 1'b0;
    hgd_pkg::hgd_frame_t i_frame = '0;
    logic i_slow = 1'b0;
    logic [63:0] amps = 64'h0400040010000800;
    logic o_frame_ready;
    logic o_gain_valid;
    logic [15:0] o_gain_lin;
    logic signed [15:0] o_gain_db;
    hgd_pkg::hgd_sample_t i_exc;
    hgd_pkg::hgd_sample_t o_exc;
    hgd_pkg::hgd_sample_t i_syn;
    logic o_syn_ready;
    hgd_pkg::hgd_sample_t o_syn;
    logic signed [15:0] gq[$];
    logic [15:0] lq[$];
    logic signed [15:0] sq[$];
    logic signed [15:0] exc_first;
    bit exc_seen = 1'b0;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    int lidx[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 7, 6, 5, 4, 3, 2, 1, 0};
    int midx[8] = '{0, 3, 1, 2, 3, 0, 2, 1};
    always #20 i_clock = ~i_clock;
    hgd_core hgd_core_inst (
        .i_clock, .i_rstn, .i_frame_valid, .i_frame, .o_frame_ready, .o_gain_valid,
        .o_gain_lin, .o_gain_db, .i_exc, .o_exc, .i_syn, .o_syn_ready, .o_syn
    );
    hgd_partner hgd_partner_inst (
        .i_clock, .i_rstn, .i_slow, .i_amps(amps), .i_ready(o_syn_ready),
        .o_exc(i_exc), .o_syn(i_syn)
    );
    always @(posedge i_clock)
    begin
        cycles++;
        if (o_gain_valid === 1'b1)
        begin
            gq.push_back(o_gain_db);
            lq.push_back(o_gain_lin);
        end
        if (o_syn.valid === 1'b1)
            sq.push_back(o_syn.data);
        if (o_exc.valid === 1'b1 && !exc_seen)
        begin
            exc_first = o_exc.data;
            exc_seen = 1'b1;
        end
        if (cycles == 30000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic near(input logic signed [31:0] got, input logic signed [31:0] exp,
        input int tol, input string msg);
        logic signed [31:0] d;
        d = got - exp;
        checked++;
        if (((d <= tol) && (d >= -tol)) !== 1'b1)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask : near
    task automatic run_frame(input hgd_pkg::hgd_size_t sz, input logic [3:0] ls,
        input logic [6:0] i1, input logic [47:0] i2, input logic signed [15:0] gm);
        int n;
        int nb;
        nb = (sz == hgd_pkg::HGD_SHORT) ? 4 : (sz == hgd_pkg::HGD_MEDIUM) ? 8 : 16;
        gq.delete();
        lq.delete();
        sq.delete();
        @(posedge i_clock);
        i_frame <= '{size: sz, loss: ls, idx1: i1, idx2: i2, g_match: gm};
        i_frame_valid <= 1'b1;
        @(negedge i_clock);
        @(posedge i_clock);
        i_frame_valid <= 1'b0;
        @(negedge i_clock);
        for (n = 0; n < 4000 && o_frame_ready !== 1'b1; n++)
            @(negedge i_clock);
        near(32'(n < 4000), 1, 0, "frame done");
        @(posedge i_clock);
        @(negedge i_clock);
        near(gq.size(), nb, 0, "gain count");
        near(sq.size(), 64 * nb, 0, "output count");
    endtask : run_frame
    task automatic t_reset();
        @(negedge i_clock);
        near(o_frame_ready, 1, 0, "ready at reset");
        near(o_gain_valid, 0, 0, "gain at reset");
    endtask : t_reset
    task automatic t_first();
        run_frame(hgd_pkg::HGD_SHORT, 4'h1, 7'h00, {48{1'b1}}, 16'sh0000);
        near(exc_first, 655, 8, "first pulse");
        near(sq[0], 2048, 16, "subframe one");
        near(sq[64], 3444, 40, "subframe two");
        near(sq[128], 1218, 40, "subframe three");
        near(sq[192], 1218, 40, "subframe four");
    endtask : t_first
    task automatic t_lost_medium();
        int k;
        run_frame(hgd_pkg::HGD_MEDIUM, 4'hF, 7'h55, 48'h0, 16'sh0000);
        for (k = 0; k < 8; k++)
        begin
            near(gq[k], -3021, 8, "lost db");
            near(lq[k], 1053, 64, "lost linear");
        end
    endtask : t_lost_medium
    task automatic t_good_short();
        logic signed [15:0] g1[$];
        real avg;
        int k;
        run_frame(hgd_pkg::HGD_SHORT, 4'hE, 7'h7F, {48{1'b1}}, 16'sh0000);
        g1 = gq;
        run_frame(hgd_pkg::HGD_SHORT, 4'hE, 7'h7F, 48'h0, 16'sh0000);
        avg = 0.0;
        for (k = 0; k < 4; k++)
        begin
            near(gq[k], g1[k], 2, "short stage two");
            avg += real'(gq[k]) / 4.0;
        end
        run_frame(hgd_pkg::HGD_SHORT, 4'h1, 7'h7F, 48'h0, 16'sh0000);
        for (k = 0; k < 4; k++)
            near(gq[k], $rtoi(0.9 * (avg + 7168.0) - 7168.0), 12, "memory");
    endtask : t_good_short
    task automatic t_long_good();
        logic [47:0] i2;
        int k;
        for (k = 0; k < 16; k++)
            i2[3 * k +: 3] = 3'(lidx[k]);
        i_slow <= 1'b1;
        run_frame(hgd_pkg::HGD_LONG, 4'b0010, 7'h00, i2, 16'sh0000);
        i_slow <= 1'b0;
        for (k = 1; k < 16; k++)
            if (k % 4 != 0)
                near(gq[k] - gq[k - 1], 768 * (lidx[k] - lidx[k - 1]), 4, "long");
    endtask : t_long_good
    task automatic t_medium_good();
        logic [47:0] i2;
        int k;
        i2 = 48'h0;
        for (k = 0; k < 8; k++)
            i2[3 * k +: 3] = 3'(4 + midx[k]);
        run_frame(hgd_pkg::HGD_MEDIUM, 4'h0, 7'h40, i2, 16'sh0000);
        for (k = 1; k < 8; k += 2)
            near(gq[k] - gq[k - 1], 768 * (midx[k] - midx[k - 1]), 4, "medium");
    endtask : t_medium_good
    task automatic t_interp();
        int k;
        run_frame(hgd_pkg::HGD_SHORT, 4'h1, 7'h00, 48'h0, 16'sh0800);
        for (k = 1; k < 4; k++)
            near(gq[k] - gq[0], 512 * k, 4, "interpolation");
    endtask : t_interp
    initial
    begin
        repeat (8) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_reset();
        t_first();
        t_lost_medium();
        t_good_short();
        t_long_good();
        t_medium_good();
        t_interp();
        tally_and_finish();
    end
endmodule : tb_hgd_core
